// [hw/tmc_edge_detect.sv]
// falling edge detector on a pin sampled once per machine cycle
`timescale 1ns/1ps
`default_nettype none
module tmc_edge_detect (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    input wire logic sample_i,
    output logic fall_o
);
    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;
    logic fall_ff;
    wire fall_now = sample_i & prev_ff & ~sync2_ff;

    // two flops before any logic reads the pin
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prev_ff <= 1'b1;
            fall_ff <= 1'b0;
        end else begin
            if (sample_i) begin
                prev_ff <= sync2_ff;
            end
            fall_ff <= fall_now;
        end
    end

    assign fall_o = fall_ff;
endmodule // tmc_edge_detect
`default_nettype wire

// [hw/tmc_pkg.sv]
// package for the timer two control and status block
package tmc_pkg;

    localparam logic [7:0] TIMER_TWO_CONTROL_ADDR = 8'hC8;
    localparam logic [7:0] CAPTURE_LOW_BYTE_ADDR = 8'hCA;
    localparam logic [7:0] CAPTURE_HIGH_BYTE_ADDR = 8'hCB;
    localparam logic [7:0] COUNT_LOW_BYTE_ADDR = 8'hCC;
    localparam logic [7:0] COUNT_HIGH_BYTE_ADDR = 8'hCD;

    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int EXTERNAL_EVENT_FLAG_BIT = 6;
    localparam int RX_BAUD_SOURCE_SELECT_BIT = 5;
    localparam int TX_BAUD_SOURCE_SELECT_BIT = 4;
    localparam int EXTERNAL_TRIGGER_ENABLE_BIT = 3;
    localparam int RUN_CONTROL_BIT = 2;
    localparam int TIMER_COUNTER_SELECT_BIT = 1;
    localparam int CAPTURE_RELOAD_SELECT_BIT = 0;

    localparam logic [7:0] TIMER_TWO_CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;

    localparam int OSC_PERIODS_PER_MACHINE_CYCLE = 12;

    typedef struct packed {
        logic overflow_flag;
        logic external_event_flag;
        logic rx_baud_source_select;
        logic tx_baud_source_select;
        logic external_trigger_enable;
        logic run_control;
        logic timer_counter_select;
        logic capture_reload_select;
    } tmc_control_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmc_sfr_req_type;

endpackage : tmc_pkg

// [hw/tmc_timer_two.sv]
// timer two control, status, counter and capture registers
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_two #(
    parameter int CYCLE_DIV = tmc_pkg::OSC_PERIODS_PER_MACHINE_CYCLE
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire tmc_pkg::tmc_sfr_req_type sfr_req_i,
    input wire logic timer_int_enable_i,
    input wire logic up_down_enable_i,
    input wire logic serial_mode_var_baud_i,
    input wire logic timer_one_overflow_i,
    input wire logic count_input_pin_i,
    input wire logic trigger_input_pin_i,
    output logic [7:0] sfr_rdata_o,
    output logic irq_o,
    output logic rx_baud_tick_o,
    output logic tx_baud_tick_o,
    output logic overflow_pulse_o
);
    import tmc_pkg::*;

    tmc_control_type ctrl_ff;
    tmc_control_type nxt_ctrl;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic [15:0] capture_ff;
    logic [15:0] nxt_capture;
    logic [3:0] div_ff;
    logic [7:0] sfr_rdata_ff;
    logic irq_ff;
    logic rx_tick_ff;
    logic tx_tick_ff;
    logic ovf_ff;
    logic count_fall;
    logic trig_fall;

    wire machine_tick = (div_ff == 4'(CYCLE_DIV - 1));
    wire baud_mode = ctrl_ff.rx_baud_source_select | ctrl_ff.tx_baud_source_select;
    wire wr_ctrl = sfr_req_i.wr & (sfr_req_i.addr == TIMER_TWO_CONTROL_ADDR);
    wire wr_cap_lo = sfr_req_i.wr & (sfr_req_i.addr == CAPTURE_LOW_BYTE_ADDR);
    wire wr_cap_hi = sfr_req_i.wr & (sfr_req_i.addr == CAPTURE_HIGH_BYTE_ADDR);
    wire wr_cnt_lo = sfr_req_i.wr & (sfr_req_i.addr == COUNT_LOW_BYTE_ADDR);
    wire wr_cnt_hi = sfr_req_i.wr & (sfr_req_i.addr == COUNT_HIGH_BYTE_ADDR);

    wire count_step = ctrl_ff.timer_counter_select ? count_fall : machine_tick;
    wire step = ctrl_ff.run_control & count_step;
    wire overflow = step & (count_ff == 16'hFFFF);
    // trigger gated by enable and baud use
    wire trig_event = trig_fall & ctrl_ff.external_trigger_enable & ~baud_mode;
    wire do_capture = trig_event & ctrl_ff.capture_reload_select;
    wire reload_ovf = overflow & (baud_mode | ~ctrl_ff.capture_reload_select);
    wire reload_trig = trig_event & ~ctrl_ff.capture_reload_select;
    wire set_ovf_flag = overflow & ~baud_mode;

    tmc_edge_detect u_count_edge (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(count_input_pin_i),
        .sample_i(machine_tick),
        .fall_o(count_fall)
    );

    tmc_edge_detect u_trig_edge (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(trigger_input_pin_i),
        .sample_i(machine_tick),
        .fall_o(trig_fall)
    );

    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = tmc_control_type'(sfr_req_i.wdata);
        end
        if (set_ovf_flag) begin
            nxt_ctrl.overflow_flag = 1'b1;
        end
        if (trig_event) begin
            nxt_ctrl.external_event_flag = 1'b1;
        end
    end

    // capture pair as destination and source
    always_comb begin
        nxt_capture = capture_ff;
        if (wr_cap_lo) begin
            nxt_capture[7:0] = sfr_req_i.wdata;
        end
        if (wr_cap_hi) begin
            nxt_capture[15:8] = sfr_req_i.wdata;
        end
        if (do_capture) begin
            nxt_capture = count_ff;
        end
    end

    // hardware reload or step overrides a same-cycle software write
    always_comb begin
        nxt_count = count_ff;
        if (wr_cnt_lo) begin
            nxt_count[7:0] = sfr_req_i.wdata;
        end
        if (wr_cnt_hi) begin
            nxt_count[15:8] = sfr_req_i.wdata;
        end
        if (reload_ovf || reload_trig) begin
            nxt_count = capture_ff;
        end else if (step) begin
            nxt_count = count_ff + 16'h0001;
        end
    end

    // read select, one named wire per mapped byte
    wire sel_ctrl = (sfr_req_i.addr == TIMER_TWO_CONTROL_ADDR);
    wire sel_cap_lo = (sfr_req_i.addr == CAPTURE_LOW_BYTE_ADDR);
    wire sel_cap_hi = (sfr_req_i.addr == CAPTURE_HIGH_BYTE_ADDR);
    wire sel_cnt_lo = (sfr_req_i.addr == COUNT_LOW_BYTE_ADDR);
    wire sel_cnt_hi = (sfr_req_i.addr == COUNT_HIGH_BYTE_ADDR);

    // per-byte read terms, zero unless selected
    wire [7:0] rd_ctrl = {8{sel_ctrl}} & ctrl_ff;
    wire [7:0] rd_cap_lo = {8{sel_cap_lo}} & capture_ff[7:0];
    wire [7:0] rd_cap_hi = {8{sel_cap_hi}} & capture_ff[15:8];
    wire [7:0] rd_cnt_lo = {8{sel_cnt_lo}} & count_ff[7:0];
    wire [7:0] rd_cnt_hi = {8{sel_cnt_hi}} & count_ff[15:8];

    // unmapped bytes read zero rather than whatever was last on the mux
    wire [7:0] rdata_mux = rd_ctrl
        | rd_cap_lo
        | rd_cap_hi
        | rd_cnt_lo
        | rd_cnt_hi;

    // read data only moves on a read, so a slow reader sees a stable byte
    wire [7:0] nxt_sfr_rdata = sfr_req_i.rd
        ? rdata_mux
        : sfr_rdata_ff;

    // divider wraps at the machine tick
    wire [3:0] nxt_div = machine_tick ? 4'h0 : div_ff + 4'h1;

    // event interrupt masked in up/down mode
    wire event_irq = ctrl_ff.external_event_flag & ~up_down_enable_i;

    // either flag may request the vector
    wire irq_source = ctrl_ff.overflow_flag | event_irq;

    // level request, it drops once software clears the flags, timer_int_enable_i falls or up/down mode masks the event flag
    wire nxt_irq = timer_int_enable_i
        & irq_source;

    wire rx_source = ctrl_ff.rx_baud_source_select
        ? overflow
        : timer_one_overflow_i;
    // fixed-rate serial modes take no tick from either timer
    wire nxt_rx_tick = serial_mode_var_baud_i & rx_source;

    wire tx_source = ctrl_ff.tx_baud_source_select
        ? overflow
        : timer_one_overflow_i;
    // same gating as the receive side
    wire nxt_tx_tick = serial_mode_var_baud_i & tx_source;

    // machine cycle divider
    // free-running, so pin samples stay evenly spaced
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // control byte with sticky flags
    // reset clears both flags as well as the control bits
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= tmc_control_type'(TIMER_TWO_CONTROL_RESET);
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // counter, reload and step already folded into nxt_count
    // software writes lose to a same-cycle reload or step
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            count_ff <= COUNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // capture pair
    // a trigger capture beats a same-cycle byte write
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            capture_ff <= CAPTURE_RESET;
        end else begin
            capture_ff <= nxt_capture;
        end
    end

    // read data register
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            sfr_rdata_ff <= 8'h00;
        end else begin
            sfr_rdata_ff <= nxt_sfr_rdata;
        end
    end

    // registered interrupt request
    // one cycle behind the flag that raises it
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    // registered receive tick
    // pulse lasts one clock, one per source overflow
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            rx_tick_ff <= 1'b0;
        end else begin
            rx_tick_ff <= nxt_rx_tick;
        end
    end

    // registered transmit tick
    // pulse lasts one clock, one per source overflow
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            tx_tick_ff <= 1'b0;
        end else begin
            tx_tick_ff <= nxt_tx_tick;
        end
    end

    // one-cycle overflow marker, seen in every mode
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ovf_ff <= 1'b0;
        end else begin
            ovf_ff <= overflow;
        end
    end

    // every output comes straight from a flop
    assign sfr_rdata_o = sfr_rdata_ff;
    assign irq_o = irq_ff;
    assign rx_baud_tick_o = rx_tick_ff;
    assign tx_baud_tick_o = tx_tick_ff;
    assign overflow_pulse_o = ovf_ff;
endmodule // tmc_timer_two
`default_nettype wire

// [verif/tmc_pin_model.sv]
// outside drive of the count and trigger pins
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model #(parameter int HOLD = 6) (
    input wire logic core_clk_i,
    input wire logic cnt_fall_i,
    input wire logic trg_fall_i,
    output logic count_pin_o,
    output logic trigger_pin_o
);
    int cnt_ff = 0;
    int trg_ff = 0;
    always_ff @(posedge core_clk_i) begin
        cnt_ff <= cnt_fall_i ? HOLD : (cnt_ff > 0 ? cnt_ff - 1 : 0);
        trg_ff <= trg_fall_i ? HOLD : (trg_ff > 0 ? trg_ff - 1 : 0);
    end
    // idle high on the port pull-ups
    assign count_pin_o = (cnt_ff == 0);
    assign trigger_pin_o = (trg_ff == 0);
endmodule // tmc_pin_model
`default_nettype wire

// [verif/tmc_timer_two_asserts.sv]
// port assertions for timer two
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_two_asserts #(parameter int CYCLE_DIV = 12) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire tmc_pkg::tmc_sfr_req_type sfr_req_i,
    input wire logic timer_int_enable_i,
    input wire logic up_down_enable_i,
    input wire logic serial_mode_var_baud_i,
    input wire logic timer_one_overflow_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic irq_o,
    input wire logic rx_baud_tick_o,
    input wire logic tx_baud_tick_o,
    input wire logic overflow_pulse_o
);
    import tmc_pkg::*;
    logic [7:0] gap_ff;
    wire logic unmapped = !(sfr_req_i.addr inside {8'hC8, [8'hCA:8'hCD]});
    // cycles since the last overflow, saturating
    always_ff @(posedge core_clk_i) begin
        gap_ff <= !rst_b_i ? 8'hFF : overflow_pulse_o ? 8'h00 : gap_ff + {7'h00, gap_ff != 8'hFF};
    end
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence rd_unmapped_s;
        sfr_req_i.rd && unmapped;
    endsequence
    unmapped_read_a: assert property (rd_unmapped_s |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!$past(sfr_req_i.rd) |-> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    irq_enable_a: assert property (irq_o |-> $past(timer_int_enable_i))
        else $error("irq without enable");
    irq_sticky_a: assert property ($fell(irq_o) |-> $past(sfr_req_i.wr) ||
        $past(sfr_req_i.wr, 2) || !$past(timer_int_enable_i) || $past(up_down_enable_i))
        else $error("irq dropped without clear");
    ovf_pulse_a: assert property (overflow_pulse_o |=> !overflow_pulse_o)
        else $error("overflow pulse too long");
    ovf_gap_a: assert property (overflow_pulse_o |-> gap_ff >= 8'(CYCLE_DIV - 1))
        else $error("overflows closer than a machine cycle");
    rx_source_a: assert property (rx_baud_tick_o |-> $past(serial_mode_var_baud_i) &&
        (overflow_pulse_o || $past(timer_one_overflow_i))) else $error("rx tick without source");
    tx_source_a: assert property (tx_baud_tick_o |-> $past(serial_mode_var_baud_i) &&
        (overflow_pulse_o || $past(timer_one_overflow_i))) else $error("tx tick without source");
endmodule // tmc_timer_two_asserts
`default_nettype wire

// [verif/tmc_timer_two_tb_top.sv]
// self-checking bench for timer two
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_two_tb_top;
    import tmc_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    tmc_sfr_req_type sfr_req_i = '0;
    logic timer_int_enable_i = 1'b0;
    logic up_down_enable_i = 1'b0;
    logic serial_mode_var_baud_i = 1'b0;
    logic timer_one_overflow_i = 1'b0;
    logic cnt_req = 1'b0;
    logic trg_req = 1'b0;
    logic count_input_pin_i, trigger_input_pin_i, irq_o, rx_baud_tick_o, tx_baud_tick_o;
    logic overflow_pulse_o;
    logic [7:0] sfr_rdata_o, cap;
    int fails = 0;
    int cmp_count = 0;
    int n;
    tmc_timer_two #(.CYCLE_DIV(2)) dut_u (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .sfr_req_i(sfr_req_i),
        .timer_int_enable_i(timer_int_enable_i),
        .up_down_enable_i(up_down_enable_i),
        .serial_mode_var_baud_i(serial_mode_var_baud_i),
        .timer_one_overflow_i(timer_one_overflow_i),
        .count_input_pin_i(count_input_pin_i),
        .trigger_input_pin_i(trigger_input_pin_i),
        .sfr_rdata_o(sfr_rdata_o),
        .irq_o(irq_o),
        .rx_baud_tick_o(rx_baud_tick_o),
        .tx_baud_tick_o(tx_baud_tick_o),
        .overflow_pulse_o(overflow_pulse_o)
    );
    tmc_pin_model pins_u (.core_clk_i(core_clk_i), .cnt_fall_i(cnt_req), .trg_fall_i(trg_req),
        .count_pin_o(count_input_pin_i), .trigger_pin_o(trigger_input_pin_i));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic complete_run;
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic sfr(input logic wr, input logic [7:0] addr, input logic [7:0] wdata);
        @(negedge core_clk_i);
        sfr_req_i = '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
        @(negedge core_clk_i);
        sfr_req_i = '0;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        sfr(1'b0, addr, 8'h00);
        chk(name, exp, sfr_rdata_o);
    endtask
    task automatic pin_fall(input logic trg);
        @(negedge core_clk_i);
        trg_req = trg;
        cnt_req = !trg;
        @(negedge core_clk_i);
        trg_req = 1'b0;
        cnt_req = 1'b0;
        repeat (16) @(negedge core_clk_i);
    endtask
    // preload near overflow, run, then look at ticks, reload and flags
    task automatic ovf_run(input logic [7:0] ctrl, input logic [7:0] exp_ctrl);
        int i;
        sfr(1'b1, CAPTURE_LOW_BYTE_ADDR, cap);
        sfr(1'b1, CAPTURE_HIGH_BYTE_ADDR, 8'hFF);
        sfr(1'b1, COUNT_HIGH_BYTE_ADDR, 8'hFF);
        sfr(1'b1, COUNT_LOW_BYTE_ADDR, 8'hFE);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, ctrl);
        for (i = 0; i < 200 && overflow_pulse_o !== 1'b1; i++) @(negedge core_clk_i);
        if (i == 200) begin
            fails++;
            complete_run();
        end
        chk("rx_tick", {7'h00, ctrl[5] & serial_mode_var_baud_i}, {7'h00, rx_baud_tick_o});
        chk("tx_tick", {7'h00, ctrl[4] & serial_mode_var_baud_i}, {7'h00, tx_baud_tick_o});
        rd_chk("reload_high", COUNT_HIGH_BYTE_ADDR, 8'hFF);
        rd_chk("flags", TIMER_TWO_CONTROL_ADDR, exp_ctrl);
    endtask
    initial begin
        void'($urandom(31008));
        cap = 8'($urandom) & 8'h7F;
        n = 1 + ($urandom % 4);
        repeat (2) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        for (int a = 8'hC8; a <= 8'hCD; a++) rd_chk("reset", a[7:0], 8'h00);
        sfr(1'b1, 8'hC9, 8'hFF);
        rd_chk("unmapped", 8'hC9, 8'h00);
        ovf_run(8'h04, 8'h84);
        timer_int_enable_i = 1'b1;
        repeat (20) @(negedge core_clk_i);
        rd_chk("sticky", TIMER_TWO_CONTROL_ADDR, 8'h84);
        chk("irq", 8'h01, {7'h00, irq_o});
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h00);
        repeat (2) @(negedge core_clk_i);
        chk("irq_clear", 8'h00, {7'h00, irq_o});
        serial_mode_var_baud_i = 1'b1;
        ovf_run(8'h35, 8'h35);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h00);
        timer_one_overflow_i = 1'b1;
        @(negedge core_clk_i);
        timer_one_overflow_i = 1'b0;
        chk("t1_rx", 8'h01, {7'h00, rx_baud_tick_o});
        serial_mode_var_baud_i = 1'b0;
        sfr(1'b1, COUNT_HIGH_BYTE_ADDR, 8'h12);
        sfr(1'b1, COUNT_LOW_BYTE_ADDR, 8'h00);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h05);
        pin_fall(1'b1);
        rd_chk("no_trigger", CAPTURE_HIGH_BYTE_ADDR, 8'hFF);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h0D);
        up_down_enable_i = 1'b1;
        pin_fall(1'b1);
        rd_chk("capture", CAPTURE_HIGH_BYTE_ADDR, 8'h12);
        chk("irq_masked", 8'h00, {7'h00, irq_o});
        up_down_enable_i = 1'b0;
        rd_chk("event_flag", TIMER_TWO_CONTROL_ADDR, 8'h4D);
        chk("irq_event", 8'h01, {7'h00, irq_o});
        sfr(1'b1, COUNT_HIGH_BYTE_ADDR, 8'h20);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h0C);
        pin_fall(1'b1);
        rd_chk("trigger_reload", COUNT_HIGH_BYTE_ADDR, 8'h12);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h06);
        sfr(1'b1, COUNT_LOW_BYTE_ADDR, 8'h00);
        repeat (n) pin_fall(1'b0);
        sfr(1'b1, TIMER_TWO_CONTROL_ADDR, 8'h02);
        pin_fall(1'b0);
        rd_chk("event_count", COUNT_LOW_BYTE_ADDR, 8'(n));
        complete_run();
    end
endmodule // tmc_timer_two_tb_top
bind tmc_timer_two tmc_timer_two_asserts #(.CYCLE_DIV(CYCLE_DIV)) chk_u (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .sfr_req_i(sfr_req_i),
    .timer_int_enable_i(timer_int_enable_i),
    .up_down_enable_i(up_down_enable_i),
    .serial_mode_var_baud_i(serial_mode_var_baud_i),
    .timer_one_overflow_i(timer_one_overflow_i),
    .sfr_rdata_o(sfr_rdata_o),
    .irq_o(irq_o),
    .rx_baud_tick_o(rx_baud_tick_o),
    .tx_baud_tick_o(tx_baud_tick_o),
    .overflow_pulse_o(overflow_pulse_o)
);
`default_nettype wire
